// [rtl/opmc_pkg.sv]
// package: register map, field layout, reset values and timing for oscillator/power mode control
package opmc_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_RC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FX_CTRL = 4'h1;
  localparam logic [3:0] ADDR_SX_CTRL = 4'h2;
  localparam logic [3:0] ADDR_SYS_CFG = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_WDT_CTRL = 4'h5;
  // internal rc control fields
  localparam int RC_EN_BIT = 0;
  localparam int RC_STABLE_BIT = 1;
  localparam int RC_FSEL_LO = 2;
  localparam int RC_FSEL_HI = 3;
  // fast crystal control fields
  localparam int FX_EN_BIT = 0;
  localparam int FX_STABLE_BIT = 1;
  localparam int FX_RANGE_BIT = 2;
  // slow crystal control fields
  localparam int SX_EN_BIT = 0;
  localparam int SX_STABLE_BIT = 1;
  // system clock config fields
  localparam int SC_SIDLE_BIT = 0;
  localparam int SC_FIDLE_BIT = 1;
  localparam int SC_LSRC_BIT = 2;
  localparam int SC_HSRC_BIT = 3;
  localparam int SC_DIV_LO = 5;
  localparam int SC_DIV_HI = 7;
  // status fields
  localparam int ST_PDF_BIT = 0;
  localparam int ST_TO_BIT = 1;
  localparam int ST_HALT_BIT = 2;
  localparam int ST_SLOW_BIT = 3;
  // watchdog control fields
  localparam int WDT_EN_BIT = 0;
  // reset values
  localparam logic [7:0] RC_CTRL_RST = 8'h01;
  localparam logic [7:0] FX_CTRL_RST = 8'h00;
  localparam logic [7:0] SX_CTRL_RST = 8'h00;
  localparam logic [7:0] SYS_CFG_RST = 8'h00;
  localparam logic WDT_EN_RST = 1'h1;
  // rc frequency codes
  localparam logic [1:0] RC_F2_A = 2'h0;
  localparam logic [1:0] RC_F4 = 2'h1;
  localparam logic [1:0] RC_F8 = 2'h2;
  // divider select codes
  localparam logic [2:0] DIV_SUB = 3'h7;
  localparam int DIV_W = 7;
  // stabilisation times, microseconds, and clock rate
  localparam int CLK_MHZ = 25;
  localparam int RC_STAB_US = 16;
  localparam int FX_STAB_US = 40;
  localparam int SX_STAB_US = 100;
  localparam int RC_STAB_CYC = RC_STAB_US * CLK_MHZ;
  localparam int FX_STAB_CYC = FX_STAB_US * CLK_MHZ;
  localparam int SX_STAB_CYC = SX_STAB_US * CLK_MHZ;
  // low-power mode encoding
  typedef enum logic [2:0]
  {
    OPMC_RUN = 3'h0,
    OPMC_SLEEP = 3'h1,
    OPMC_IDLE_SUB = 3'h2,
    OPMC_IDLE_BOTH = 3'h3,
    OPMC_IDLE_FAST = 3'h4
  } opmc_mode_e;
endpackage

// [rtl/opmc_stab_if.sv]
// interface: start request and stable answer between control and a stabilisation timer
`timescale 1ns/1ps
interface opmc_stab_if;
  logic enable;
  logic restart;
  logic stable;
  modport ctrl (output enable, output restart, input stable);
  modport timer (input enable, input restart, output stable);
endinterface

// [rtl/opmc_stab_timer.sv]
// stabilisation timer: counts cycles after enable or restart, then reports stable
`timescale 1ns/1ps
module opmc_stab_timer
  import opmc_pkg::*;
#(
  parameter int STAB_CYC = 400
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control side
  opmc_stab_if.timer stab
);
  localparam int CW = $clog2(STAB_CYC + 1);
  logic [CW-1:0] count;

  initial
  begin
    if (STAB_CYC < 1)
      $error("stabilisation count must be at least one cycle");
  end

  // restart drops the flag at once and reloads the count [RL23] [RL3]
  always_ff @(posedge clk)
  begin
    if (srst || !stab.enable || stab.restart)
      count <= '0;
    else if (count != CW'(STAB_CYC))
      count <= count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst || !stab.enable || stab.restart)
      stab.stable <= 1'b0;
    else
      stab.stable <= (count == CW'(STAB_CYC - 1)) || stab.stable;
  end
endmodule

// [rtl/opmc_clk_div.sv]
// system clock divider: one-cycle enable pulse at fast/1..64 or at the subclock rate
`timescale 1ns/1ps
module opmc_clk_div
  import opmc_pkg::*;
#(
  parameter int SUB_DIV = 763
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // rate control
  input wire logic fast_run,
  input wire logic sub_run,
  input wire logic [2:0] div_sel,
  // enables
  output logic sys_ce,
  output logic sub_ce
);
  localparam int SW = $clog2(SUB_DIV);
  logic [DIV_W-1:0] fast_count;
  logic [SW-1:0] sub_count;
  logic [DIV_W-1:0] mask;

  initial
  begin
    if (SUB_DIV < 2)
      $error("subclock divide must be at least two");
  end

  always_comb
  begin
    mask = DIV_W'((1 << div_sel) - 1);
  end

  always_ff @(posedge clk)
  begin
    if (srst || !fast_run)
      fast_count <= '0;
    else
      fast_count <= fast_count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst || !sub_run || sub_count == SW'(SUB_DIV - 1))
      sub_count <= '0;
    else
      sub_count <= sub_count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      sub_ce <= 1'b0;
    else
      sub_ce <= sub_run && sub_count == '0;
  end

  // divide codes 000..110 give fast/1..fast/64, 111 gives subclock [RL13] [RL12]
  always_ff @(posedge clk)
  begin
    if (srst)
      sys_ce <= 1'b0;
    else if (div_sel == DIV_SUB)
      sys_ce <= sub_run && sub_count == '0;
    else
      sys_ce <= fast_run && ((fast_count & mask) == '0);
  end
endmodule

// [rtl/opmc_top.sv]
// top: oscillator enables, stable flags, clock switching and halt low-power modes
//
// Functional notes
// RL1 - rc frequency codes 00 and 11 give 2MHz, 01 4MHz, 10 8MHz.
// RL2 - new rc frequency reaches the clock only after rc stable flag sets.
// RL3 - rc stable flag clears on enable or retune, sets once stable.
// RL4 - rc enable bit gates the rc oscillator and resets to one.
// RL5 - crystal range bit: 0 up to 10MHz, 1 above; resets to 0.
// RL6 - software sets range before crystal enable and leaves it while enabled.
// RL7 - fast crystal stable flag clears on enable, sets once stable.
// RL8 - fast crystal enable bit stops or starts it, resets to 0.
// RL9 - slow crystal stable flag clears on enable, sets once stable.
// RL10 - slow crystal enable bit stops or starts it, resets to 0.
// RL11 - unimplemented upper bits of oscillator controls read zero.
// RL12 - divider code 111 moves to subclock after its source is stable.
// RL13 - divider codes 000..110 give fast clock divided 1 to 64.
// RL14 - return to fast clock waits for the fast source stable flag.
// RL15 - halt with both keep bits 0 enters sleep, all clocks stopped.
// RL16 - halt with fast keep 0, slow keep 1: subclock only idle.
// RL17 - halt with both keep bits 1: idle with both clocks.
// RL18 - halt with fast keep 1, slow keep 0: fast clock only idle.
// RL19 - halt stops execution and holds memory, registers and ports.
// RL20 - halt sets power-down flag and clears watchdog timeout flag.
// RL21 - halt clears watchdog counter; it resumes only if watchdog enabled.
// RL22 - high source select 0 picks rc, 1 picks fast crystal.
// RL23 - stable flags come from restartable counters of parameter length.
`timescale 1ns/1ps
module opmc_top
  import opmc_pkg::*;
#(
  parameter int RC_STAB = RC_STAB_CYC,
  parameter int FX_STAB = FX_STAB_CYC,
  parameter int SX_STAB = SX_STAB_CYC,
  parameter int SUB_DIV = 763
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // cpu side
  input wire logic HALT_REQ,
  input wire logic WAKE,
  input wire logic WDT_TIMEOUT,
  output logic CPU_STALL,
  output logic WDT_CLEAR,
  output logic WDT_RUN,
  // oscillator cores
  output logic RC_EN,
  output logic [1:0] RC_FSEL,
  output logic FX_EN,
  output logic FX_RANGE,
  output logic SX_EN,
  // clock outputs
  output logic HIGH_SRC,
  output logic LOW_SRC,
  output logic SYS_CE,
  output logic SUB_CE,
  output logic FAST_ON,
  output logic SUB_ON
);
  opmc_stab_if rc_stab ();
  opmc_stab_if fx_stab ();
  opmc_stab_if sx_stab ();

  logic rc_en;
  logic [1:0] rc_fsel;
  logic [1:0] rc_fsel_applied;
  logic fx_en;
  logic fx_range;
  logic sx_en;
  logic [2:0] div_sel;
  logic [2:0] div_applied;
  logic high_src;
  logic low_src;
  logic fast_keep;
  logic slow_keep;
  logic power_down_flag;
  logic to_flag;
  logic wdt_en;
  opmc_mode_e mode;
  opmc_mode_e next_mode;
  logic wr_rc;
  logic wr_fx;
  logic wr_sx;
  logic wr_sc;
  logic fast_stable;
  logic sub_stable;
  logic fast_run;
  logic sub_run;
  logic sys_ce;
  logic sub_ce;
  logic [7:0] next_rdata;
  logic rc_restart;

  initial
  begin
    if (RC_STAB < 1 || FX_STAB < 1 || SX_STAB < 1)
      $error("stabilisation counts must be at least one cycle");
  end

  always_comb
  begin
    wr_rc = WR && ADDR == ADDR_RC_CTRL;
    wr_fx = WR && ADDR == ADDR_FX_CTRL;
    wr_sx = WR && ADDR == ADDR_SX_CTRL;
    wr_sc = WR && ADDR == ADDR_SYS_CFG;
  end

  // enabling or retuning the rc restarts its settle count [RL3]
  always_comb
  begin
    rc_restart = wr_rc && WDATA[RC_EN_BIT] &&
      (!rc_en || WDATA[RC_FSEL_HI:RC_FSEL_LO] != rc_fsel);
  end

  // oscillators are held running in idle modes that keep them
  always_comb
  begin
    case (mode)
      OPMC_RUN:
      begin
        fast_run = div_sel != DIV_SUB || div_applied != DIV_SUB;
        sub_run = 1'b1;
      end
      OPMC_SLEEP:
      begin
        fast_run = 1'b0; // [RL15]
        sub_run = 1'b0;
      end
      OPMC_IDLE_SUB:
      begin
        fast_run = 1'b0; // [RL16]
        sub_run = 1'b1;
      end
      OPMC_IDLE_BOTH:
      begin
        fast_run = 1'b1; // [RL17]
        sub_run = 1'b1;
      end
      OPMC_IDLE_FAST:
      begin
        fast_run = 1'b1; // [RL18]
        sub_run = 1'b0;
      end
      default:
      begin
        fast_run = 1'b0;
        sub_run = 1'b0;
      end
    endcase
  end

  // stabilisation timers per oscillator [RL23]
  // an unselected fast oscillator may run only while the cpu runs or an idle mode keeps the fast clock
  assign rc_stab.enable = rc_en && (fast_run || (high_src && mode == OPMC_RUN));
  assign rc_stab.restart = rc_restart;
  assign fx_stab.enable = fx_en && (fast_run || (!high_src && mode == OPMC_RUN));
  assign fx_stab.restart = wr_fx && WDATA[FX_EN_BIT] && !fx_en; // [RL7]
  // stopped crystal must settle again after wake
  assign sx_stab.enable = sx_en && sub_run;
  assign sx_stab.restart = wr_sx && WDATA[SX_EN_BIT] && !sx_en; // [RL9]

  opmc_stab_timer #(.STAB_CYC(RC_STAB)) u_rc_timer (.clk(SYS_CLK), .srst(SRST), .stab(rc_stab.timer));
  opmc_stab_timer #(.STAB_CYC(FX_STAB)) u_fx_timer (.clk(SYS_CLK), .srst(SRST), .stab(fx_stab.timer));
  opmc_stab_timer #(.STAB_CYC(SX_STAB)) u_sx_timer (.clk(SYS_CLK), .srst(SRST), .stab(sx_stab.timer));

  // high source 0 is rc, 1 is fast crystal; low source 0 internal slow rc [RL22]
  always_comb
  begin
    fast_stable = high_src ? fx_stab.stable : rc_stab.stable;
    sub_stable = low_src ? sx_stab.stable : 1'b1;
  end

  // internal rc control register
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      rc_en <= RC_CTRL_RST[RC_EN_BIT]; // [RL4]
      rc_fsel <= RC_CTRL_RST[RC_FSEL_HI:RC_FSEL_LO];
    end
    else if (wr_rc)
    begin
      rc_en <= WDATA[RC_EN_BIT]; // [RL4]
      rc_fsel <= WDATA[RC_FSEL_HI:RC_FSEL_LO];
    end
  end

  // retuned frequency takes effect only after the flag rises [RL2]
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      rc_fsel_applied <= RC_CTRL_RST[RC_FSEL_HI:RC_FSEL_LO];
    else if (rc_stab.stable && !rc_restart)
      rc_fsel_applied <= rc_fsel;
  end

  // fast crystal control; range change while enabled is software's fault [RL6]
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      fx_en <= FX_CTRL_RST[FX_EN_BIT]; // [RL8]
      fx_range <= FX_CTRL_RST[FX_RANGE_BIT]; // [RL5]
    end
    else if (wr_fx)
    begin
      fx_en <= WDATA[FX_EN_BIT]; // [RL8]
      fx_range <= WDATA[FX_RANGE_BIT]; // [RL5]
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      sx_en <= SX_CTRL_RST[SX_EN_BIT]; // [RL10]
    else if (wr_sx)
      sx_en <= WDATA[SX_EN_BIT]; // [RL10]
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      div_sel <= SYS_CFG_RST[SC_DIV_HI:SC_DIV_LO];
      high_src <= SYS_CFG_RST[SC_HSRC_BIT];
      low_src <= SYS_CFG_RST[SC_LSRC_BIT];
      fast_keep <= SYS_CFG_RST[SC_FIDLE_BIT];
      slow_keep <= SYS_CFG_RST[SC_SIDLE_BIT];
    end
    else if (wr_sc)
    begin
      div_sel <= WDATA[SC_DIV_HI:SC_DIV_LO];
      high_src <= WDATA[SC_HSRC_BIT];
      low_src <= WDATA[SC_LSRC_BIT];
      fast_keep <= WDATA[SC_FIDLE_BIT];
      slow_keep <= WDATA[SC_SIDLE_BIT];
    end
  end

  // switch is held until the target source is stable; old rate runs meanwhile
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      div_applied <= SYS_CFG_RST[SC_DIV_HI:SC_DIV_LO];
    else if (div_sel == DIV_SUB && sub_stable)
      div_applied <= div_sel; // [RL12]
    else if (div_sel != DIV_SUB && fast_stable)
      div_applied <= div_sel; // [RL14] [RL13]
  end

  // watchdog enable and status flags; timeout set wins over halt clear
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      wdt_en <= WDT_EN_RST;
    else if (WR && ADDR == ADDR_WDT_CTRL)
      wdt_en <= WDATA[WDT_EN_BIT];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      power_down_flag <= 1'b0;
    else if (mode == OPMC_RUN && HALT_REQ)
      power_down_flag <= 1'b1; // [RL20]
    else if (WR && ADDR == ADDR_STATUS && WDATA[ST_PDF_BIT])
      power_down_flag <= 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      to_flag <= 1'b0;
    else if (WDT_TIMEOUT)
      to_flag <= 1'b1;
    else if (mode == OPMC_RUN && HALT_REQ)
      to_flag <= 1'b0; // [RL20]
  end

  // halt picks the low-power mode from the two keep bits
  always_comb
  begin
    next_mode = mode;
    case (mode)
      OPMC_RUN:
      begin
        if (HALT_REQ)
        begin
          case ({fast_keep, slow_keep})
            2'h0: next_mode = OPMC_SLEEP; // [RL15]
            2'h1: next_mode = OPMC_IDLE_SUB; // [RL16]
            2'h3: next_mode = OPMC_IDLE_BOTH; // [RL17]
            2'h2: next_mode = OPMC_IDLE_FAST; // [RL18]
            default: next_mode = OPMC_SLEEP;
          endcase
        end
      end
      OPMC_SLEEP, OPMC_IDLE_SUB, OPMC_IDLE_BOTH, OPMC_IDLE_FAST:
      begin
        if (WAKE || WDT_TIMEOUT)
          next_mode = OPMC_RUN;
      end
      default: next_mode = OPMC_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      mode <= OPMC_RUN;
    else
      mode <= next_mode;
  end

  opmc_clk_div #(.SUB_DIV(SUB_DIV)) u_div (
    .clk(SYS_CLK),
    .srst(SRST),
    .fast_run(fast_run && fast_stable && mode == OPMC_RUN),
    .sub_run(sub_run && sub_stable),
    .div_sel(div_applied),
    .sys_ce(sys_ce),
    .sub_ce(sub_ce)
  );

  // read mux; unimplemented bits return zero [RL11]
  always_comb
  begin
    next_rdata = 8'h00;
    case (ADDR)
      ADDR_RC_CTRL: next_rdata = {4'h0, rc_fsel, rc_stab.stable, rc_en}; // [RL3] [RL11]
      ADDR_FX_CTRL: next_rdata = {5'h00, fx_range, fx_stab.stable, fx_en}; // [RL7] [RL11]
      ADDR_SX_CTRL: next_rdata = {6'h00, sx_stab.stable, sx_en}; // [RL9] [RL11]
      ADDR_SYS_CFG: next_rdata = {div_sel, 1'b0, high_src, low_src, fast_keep, slow_keep};
      ADDR_STATUS: next_rdata = {4'h0, div_applied == DIV_SUB, mode != OPMC_RUN, to_flag, power_down_flag};
      ADDR_WDT_CTRL: next_rdata = {7'h00, wdt_en};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= next_rdata;
    else
      RDATA <= 8'h00;
  end

  // registered outputs to cores and cpu
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      RC_EN <= RC_CTRL_RST[RC_EN_BIT];
      RC_FSEL <= RC_CTRL_RST[RC_FSEL_HI:RC_FSEL_LO];
      FX_EN <= 1'b0;
      FX_RANGE <= 1'b0;
      SX_EN <= 1'b0;
      HIGH_SRC <= 1'b0;
      LOW_SRC <= 1'b0;
      SYS_CE <= 1'b0;
      SUB_CE <= 1'b0;
      FAST_ON <= 1'b0;
      SUB_ON <= 1'b0;
      CPU_STALL <= 1'b0;
      WDT_CLEAR <= 1'b0;
      WDT_RUN <= WDT_EN_RST;
    end
    else
    begin
      RC_EN <= rc_stab.enable; // [RL4]
      RC_FSEL <= rc_fsel_applied; // [RL1] [RL2]
      FX_EN <= fx_stab.enable; // [RL8]
      FX_RANGE <= fx_range;
      SX_EN <= sx_en && sub_run; // [RL10]
      HIGH_SRC <= high_src; // [RL22]
      LOW_SRC <= low_src;
      SYS_CE <= sys_ce && mode == OPMC_RUN; // [RL19]
      SUB_CE <= sub_ce;
      FAST_ON <= fast_run;
      SUB_ON <= sub_run;
      CPU_STALL <= next_mode != OPMC_RUN; // [RL19]
      WDT_CLEAR <= mode == OPMC_RUN && HALT_REQ; // [RL21]
      WDT_RUN <= wdt_en; // [RL21]
    end
  end
endmodule

// [test/opmc_top_assertions.sv]
// checker: port-level properties of oscillator and power mode control
`timescale 1ns/1ps
module opmc_top_assertions
  import opmc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // cpu side
  input wire logic HALT_REQ,
  input wire logic CPU_STALL,
  input wire logic WDT_CLEAR,
  // oscillators and clocks
  input wire logic FX_EN,
  input wire logic SX_EN,
  input wire logic SYS_CE,
  input wire logic FAST_ON,
  input wire logic SUB_ON
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic [1:0] keep;
  logic halt_taken;
  // keep bits shadowed from writes, the config register is not visible here
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      keep <= 2'h0;
    else if (WR && ADDR == ADDR_SYS_CFG)
      keep <= WDATA[SC_FIDLE_BIT:SC_SIDLE_BIT];
  end
  assign halt_taken = HALT_REQ && !CPU_STALL;
  a_halt_stalls: assert property (halt_taken |=> CPU_STALL)
    else $error("halt did not stall the cpu");
  a_wdt_clear_once: assert property (halt_taken |=> WDT_CLEAR ##1 !WDT_CLEAR)
    else $error("watchdog clear not a single pulse after halt");
  a_no_sys_ce: assert property (CPU_STALL && $past(CPU_STALL) |-> !SYS_CE)
    else $error("system clock enable while halted");
  a_fast_stops: assert property (CPU_STALL && $past(CPU_STALL, 3) && !keep[1] |-> !FAST_ON)
    else $error("fast clock kept without fast keep bit");
  a_sub_stops: assert property (CPU_STALL && $past(CPU_STALL, 3) && !keep[0] |-> !SUB_ON)
    else $error("subclock kept without slow keep bit");
  a_rc_upper: assert property ($past(RD) && $past(ADDR) == ADDR_RC_CTRL |-> RDATA[7:4] == 4'h0)
    else $error("rc control upper bits not zero");
  a_fx_upper: assert property ($past(RD) && $past(ADDR) == ADDR_FX_CTRL |-> RDATA[7:3] == 5'h00)
    else $error("fast crystal upper bits not zero");
  a_sx_upper: assert property ($past(RD) && $past(ADDR) == ADDR_SX_CTRL |-> RDATA[7:2] == 6'h00)
    else $error("slow crystal upper bits not zero");
  a_fx_enable: assert property (WR && ADDR == ADDR_FX_CTRL && !CPU_STALL |->
    ##2 FX_EN == $past(WDATA[FX_EN_BIT], 2))
    else $error("fast crystal enable does not follow write");
  a_sx_enable: assert property (WR && ADDR == ADDR_SX_CTRL && !CPU_STALL |->
    ##2 SX_EN == $past(WDATA[SX_EN_BIT], 2))
    else $error("slow crystal enable does not follow write");
  c_halt: cover property (halt_taken);
  c_slow: cover property (WR && ADDR == ADDR_SYS_CFG && WDATA[7:5] == DIV_SUB);
  c_clear: cover property (WDT_CLEAR);
endmodule
bind opmc_top opmc_top_assertions i_opmc_top_assertions (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HALT_REQ(HALT_REQ), .CPU_STALL(CPU_STALL),
  .WDT_CLEAR(WDT_CLEAR), .FX_EN(FX_EN), .SX_EN(SX_EN), .SYS_CE(SYS_CE), .FAST_ON(FAST_ON), .SUB_ON(SUB_ON));

// [test/opmc_cpu_model.sv]
// model of the cpu halt logic: halt, wake and watchdog timeout pulses
`timescale 1ns/1ps
module opmc_cpu_model
(
  // clock
  input wire logic clk,
  // design side
  input wire logic cpu_stall,
  output logic halt_req,
  output logic wake,
  output logic wdt_timeout
);
  initial
  begin
    halt_req = 1'b0;
    wake = 1'b0;
    wdt_timeout = 1'b0;
  end
  // a stalled cpu executes nothing, so no halt is issued then
  task automatic halt();
    @(posedge clk);
    if (cpu_stall === 1'b0)
      halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
  endtask
  task automatic wake_up();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
  endtask
  task automatic timeout();
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
// testbench: registers, clock switching and low-power modes
`timescale 1ns/1ps
module tb_top
  import opmc_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic HALT_REQ, WAKE, WDT_TIMEOUT, CPU_STALL, WDT_CLEAR, WDT_RUN, RC_EN, FX_EN, FX_RANGE, SX_EN;
  logic HIGH_SRC, LOW_SRC, SYS_CE, SUB_CE, FAST_ON, SUB_ON;
  logic [1:0] RC_FSEL, c, p;
  logic [7:0] RDATA, d;
  int errors = 0;
  int samples_checked = 0;
  int n, w;
  always #20 SYS_CLK = ~SYS_CLK;
  // short stabilisation counts keep the run brief
  opmc_top #(.RC_STAB(6), .FX_STAB(8), .SX_STAB(10), .SUB_DIV(2)) i_opmc_top (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HALT_REQ(HALT_REQ), .WAKE(WAKE),
    .WDT_TIMEOUT(WDT_TIMEOUT), .CPU_STALL(CPU_STALL), .WDT_CLEAR(WDT_CLEAR), .WDT_RUN(WDT_RUN), .RC_EN(RC_EN),
    .RC_FSEL(RC_FSEL), .FX_EN(FX_EN), .FX_RANGE(FX_RANGE), .SX_EN(SX_EN), .HIGH_SRC(HIGH_SRC),
    .LOW_SRC(LOW_SRC), .SYS_CE(SYS_CE), .SUB_CE(SUB_CE), .FAST_ON(FAST_ON), .SUB_ON(SUB_ON));
  opmc_cpu_model i_opmc_cpu_model (.clk(SYS_CLK), .cpu_stall(CPU_STALL), .halt_req(HALT_REQ), .wake(WAKE),
    .wdt_timeout(WDT_TIMEOUT));
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic give_up();
    errors++;
    results();
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    for (int k = 0; k < 100; k++)
    begin
      rd(a, d);
      if (d[b] === v)
        return;
    end
    give_up();
  endtask
  // two old-rate pulses can follow the write, so only the last gap counts
  task automatic gap(output int g);
    for (int k = 0; k < 4; k++)
    begin
      g = 0;
      do
      begin
        @(posedge SYS_CLK);
        #1 g++;
      end
      while (SYS_CE !== 1'b1 && g < 300);
      if (g >= 300)
        give_up();
    end
  endtask
  initial
  begin
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rd(ADDR_RC_CTRL, d);
    check("rc reset", d & 8'hFD, RC_CTRL_RST);
    rd(ADDR_FX_CTRL, d);
    check("fx reset", d, FX_CTRL_RST);
    rd(ADDR_SX_CTRL, d);
    check("sx reset", d, SX_CTRL_RST);
    check("osc pins", {5'h0, RC_EN, FX_EN, SX_EN}, 8'h04);
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    check("unmapped", d, 8'h00);
    wr(ADDR_SX_CTRL, 8'hFF);
    rd(ADDR_SX_CTRL, d);
    check("sx start", d, 8'h01);
    check("sx pin", 8'(SX_EN), 8'h01);
    poll(ADDR_SX_CTRL, SX_STABLE_BIT, 1'b1);
    wr(ADDR_FX_CTRL, 8'h04);
    wr(ADDR_FX_CTRL, 8'h05);
    rd(ADDR_FX_CTRL, d);
    check("fx start", d, 8'h05);
    check("fx pins", {6'h0, FX_RANGE, FX_EN}, 8'h03);
    poll(ADDR_FX_CTRL, FX_STABLE_BIT, 1'b1);
    p = 2'h0;
    for (int i = 1; i <= 4; i++)
    begin
      c = 2'(i);
      wr(ADDR_RC_CTRL, {4'hF, c, 2'h1});
      check("fsel held", 8'(RC_FSEL), 8'(p));
      rd(ADDR_RC_CTRL, d);
      check("rc restart", d, {4'h0, c, 2'h1});
      poll(ADDR_RC_CTRL, RC_STABLE_BIT, 1'b1);
      repeat (2) @(posedge SYS_CLK);
      #1 check("fsel applied", 8'(RC_FSEL), 8'(c));
      p = c;
    end
    wr(ADDR_SYS_CFG, 8'h0C);
    rd(ADDR_STATUS, d);
    check("sources", {6'h0, HIGH_SRC, LOW_SRC}, 8'h03);
    for (int k = 0; k < 7; k++)
    begin
      wr(ADDR_SYS_CFG, {3'(k), 5'h0C});
      gap(n);
      check("divider", 8'(n), 8'(1 << k));
    end
    wr(ADDR_SX_CTRL, 8'h00);
    wr(ADDR_SX_CTRL, 8'h01);
    wr(ADDR_SYS_CFG, 8'hEC);
    rd(ADDR_STATUS, d);
    check("slow early", 8'(d[ST_SLOW_BIT]), 8'h00);
    poll(ADDR_STATUS, ST_SLOW_BIT, 1'b1);
    repeat (2) @(posedge SYS_CLK);
    #1 check("fast off", 8'(FAST_ON), 8'h00);
    gap(n);
    check("sub rate", 8'(n), 8'h02);
    check("sub ce", {6'h0, SYS_CE, SUB_CE}, 8'h03);
    wr(ADDR_SYS_CFG, 8'h0C);
    rd(ADDR_STATUS, d);
    check("fast early", 8'(d[ST_SLOW_BIT]), 8'h01);
    poll(ADDR_STATUS, ST_SLOW_BIT, 1'b0);
    rd(ADDR_FX_CTRL, d);
    check("fx back", {d[6:0], FAST_ON}, 8'h0F);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_WDT_CTRL, 8'(k));
      @(posedge SYS_CLK);
      #1 check("wdt run", 8'(WDT_RUN), 8'(k));
    end
    for (int k = 0; k < 4; k++)
    begin
      i_opmc_cpu_model.timeout();
      rd(ADDR_STATUS, d);
      check("timeout set", 8'(d[ST_TO_BIT]), 8'h01);
      wr(ADDR_SYS_CFG, 8'h0C | 8'(k));
      i_opmc_cpu_model.halt();
      repeat (3) @(posedge SYS_CLK);
      #1 check("idle clocks", {5'h0, CPU_STALL, FAST_ON, SUB_ON}, {5'h0, 1'b1, 2'(k)});
      i_opmc_cpu_model.wake_up();
      for (w = 0; w < 50 && CPU_STALL !== 1'b0; w++)
        @(posedge SYS_CLK);
      if (w == 50)
        give_up();
      rd(ADDR_STATUS, d);
      check("halt flags", 8'(d[1:0]), 8'h01);
      wr(ADDR_STATUS, 8'h01);
      rd(ADDR_FX_CTRL, d);
      check("regs kept", d & 8'hFD, 8'h05);
    end
    results();
  end
endmodule
